//--- lmme_core.sv
/*
 * execution of four single-word, single-cycle instructions: literal to
 * bank pointer, literal to accumulator, accumulator to data memory, and
 * accumulator times literal into the product pair.
 * assumes: instruction word, valid, extended-set enable and index base
 * come from logic on SYS_CLK; data memory writes on an edge with WE high.
 */
// Summary of operation
// RULE1: load-accumulator opcode 0x0e copies literal into accumulator, no flags touched.
// RULE2: load-accumulator is one word, one cycle; decode, read, process, write q4.
// RULE3: load-bank decodes q1, reads literal q2, processes q3, writes pointer q4.
// RULE4: load-bank opcode 0x01; pointer upper four bits always read zero.
// RULE5: store opcode 0110111a writes accumulator to addressed location, no flags.
// RULE6: access bit zero selects access bank; one uses bank pointer for bank.
// RULE7: extended set, access bit zero, address up to 95: indexed literal offset.
// RULE8: store is one word, one cycle; read target q2, write target q4.
// RULE9: multiply gives unsigned accumulator times literal; high byte to product high.
// RULE10: multiply keeps accumulator and flags; no carry, overflow or zero indication.
// RULE11: multiply opcode 0x0d, one cycle; literal read q2, products written q4.
// RULE12: decoder matches whole upper byte; store's access bit is an operand.
`timescale 1ns/1ps
module lmme_core (
    input  wire logic        SYS_CLK,      // 125 mhz system clock
    input  wire logic        RST_N,        // sync reset, active low
    input  wire logic        INSTR_VALID,  // instruction word offered
    input  wire logic [15:0] INSTR,        // 16-bit instruction word
    input  wire logic        EXT_SET_EN,   // extended instruction set on
    input  wire logic [11:0] INDEX_BASE,   // base for indexed addressing
    input  wire logic [7:0]  MEM_RDATA,    // data read from target
    output logic      [1:0]  Q_PHASE,      // current phase, 0 = q1
    output logic      [7:0]  ACC,          // working accumulator
    output logic      [7:0]  BANK_PTR,     // bank pointer register
    output logic      [7:0]  PRODUCT_HIGH, // product high byte
    output logic      [7:0]  PRODUCT_LOW,  // product low byte
    output logic      [11:0] MEM_ADDR,     // data memory address
    output logic      [7:0]  MEM_WDATA,    // data memory write data
    output logic             MEM_RE,       // target read strobe
    output logic             MEM_WE,       // target write strobe
    output logic             INSTR_DONE,   // instruction retired
    output logic             INSTR_UNKNOWN // word not handled here
);

    // ------------------------------------------------------------------
    // phase sequencer and multiplier
    // ------------------------------------------------------------------
    lmme_pkg::lmme_phase_e phase;
    logic [15:0]           prod_w;
    logic [7:0]            lit;

    lmme_phase u_phase (
        .clk   (SYS_CLK),
        .rst_n (RST_N),
        .phase (phase)
    );

    lmme_mul8 #(
        .W (lmme_pkg::DATA_W)
    ) u_mul (
        .a (ACC),
        .b (lit),
        .p (prod_w)
    );

    assign Q_PHASE = phase;

    // ------------------------------------------------------------------
    // state
    // ------------------------------------------------------------------
    lmme_pkg::lmme_op_e op;
    lmme_pkg::lmme_op_e next_op;
    logic [15:0] ir;
    logic [15:0] next_ir;
    logic [7:0]  next_lit;
    logic [15:0] result;
    logic [15:0] next_result;
    logic [7:0]  next_acc;
    logic [7:0]  next_bank_ptr;
    logic [7:0]  next_product_high;
    logic [7:0]  next_product_low;
    logic [11:0] next_mem_addr;
    logic [7:0]  next_mem_wdata;
    logic        next_mem_re;
    logic        next_mem_we;
    logic        next_instr_done;
    logic        next_instr_unknown;
    logic [7:0]  read_back;
    logic [7:0]  next_read_back;

    // ------------------------------------------------------------------
    // decode
    // ------------------------------------------------------------------
    function automatic lmme_pkg::lmme_op_e decode(input logic [15:0] w);
        logic [7:0] hi;
        hi = w[15:lmme_pkg::OPC_BYTE_LSB];
        if (hi == lmme_pkg::OPC_LOAD_BANK) begin                // see RULE4
            decode = lmme_pkg::OP_LOAD_BANK;
        end else if (hi == lmme_pkg::OPC_LOAD_ACC) begin        // see RULE1
            decode = lmme_pkg::OP_LOAD_ACC;
        end else if (hi == lmme_pkg::OPC_MULTIPLY) begin        // see RULE11
            decode = lmme_pkg::OP_MULTIPLY;
        end else if (w[15:lmme_pkg::OPC_STORE_LSB] == lmme_pkg::OPC_STORE) begin
            decode = lmme_pkg::OP_STORE;                         // see RULE12
        end else begin
            decode = lmme_pkg::OP_NONE;
        end
    endfunction

    // ------------------------------------------------------------------
    // target address of a store
    // ------------------------------------------------------------------
    function automatic logic [11:0] store_addr(
        input logic [15:0] w,
        input logic [7:0]  bank,
        input logic        ext_en,
        input logic [11:0] base
    );
        logic [7:0] f;
        f = w[7:0];
        if (w[lmme_pkg::ACCESS_BIT]) begin
            store_addr = {bank[3:0], f};                          // see RULE6
        end else if (ext_en && (f <= lmme_pkg::ACCESS_LOW_MAX)) begin
            // wraps in the 4k data space rather than faulting
            store_addr = base + {4'h0, f};                        // see RULE7
        end else if (f <= lmme_pkg::ACCESS_LOW_MAX) begin
            store_addr = {lmme_pkg::ACCESS_LOW_PAGE, f};          // see RULE6
        end else begin
            store_addr = {lmme_pkg::ACCESS_HIGH_PAGE, f};
        end
    endfunction

    // ------------------------------------------------------------------
    // next-state logic
    // ------------------------------------------------------------------
    always_comb begin
        next_op            = op;
        next_ir            = ir;
        next_lit           = lit;
        next_result        = result;
        next_acc           = ACC;
        next_bank_ptr      = BANK_PTR;
        next_product_high  = PRODUCT_HIGH;
        next_product_low   = PRODUCT_LOW;
        next_mem_addr      = MEM_ADDR;
        next_mem_wdata     = MEM_WDATA;
        next_mem_re        = 1'b0;
        next_mem_we        = 1'b0;
        next_instr_done    = 1'b0;
        next_instr_unknown = 1'b0;
        next_read_back     = read_back;
        unique case (phase)
            lmme_pkg::PH_Q1: begin
                // decode; no valid word means an idle cycle
                if (INSTR_VALID) begin
                    next_ir            = INSTR;
                    next_op            = decode(INSTR);             // see RULE12
                    next_instr_unknown = (decode(INSTR) == lmme_pkg::OP_NONE);
                end else begin
                    next_op = lmme_pkg::OP_NONE;
                end
            end
            lmme_pkg::PH_Q2: begin
                // literal read for every op; store also reads its target
                next_lit = ir[7:0];                                  // see RULE2
                if (op == lmme_pkg::OP_STORE) begin
                    next_mem_addr = store_addr(ir, BANK_PTR,
                                               EXT_SET_EN, INDEX_BASE);
                    next_mem_re   = 1'b1;                            // see RULE8
                end
            end
            lmme_pkg::PH_Q3: begin
                // process data
                unique case (op)
                    lmme_pkg::OP_LOAD_BANK: begin
                        next_result = {8'h00, lit & lmme_pkg::BANK_WRITE_MASK}; // see RULE4
                    end
                    lmme_pkg::OP_LOAD_ACC: begin
                        next_result = {8'h00, lit};                  // see RULE1
                    end
                    lmme_pkg::OP_MULTIPLY: begin
                        next_result = prod_w;                        // see RULE9
                    end
                    lmme_pkg::OP_STORE: begin
                        // target value is read but the store discards it
                        next_read_back = MEM_RDATA;
                        next_mem_wdata = ACC;                        // see RULE5
                    end
                    lmme_pkg::OP_NONE: begin
                        next_result = result;
                    end
                    default: begin
                        next_result = result;
                    end
                endcase
            end
            lmme_pkg::PH_Q4: begin
                // write back; no status flag exists to touch
                unique case (op)
                    lmme_pkg::OP_LOAD_BANK: begin
                        next_bank_ptr = result[7:0];                 // see RULE3
                    end
                    lmme_pkg::OP_LOAD_ACC: begin
                        next_acc = result[7:0];                      // see RULE2
                    end
                    lmme_pkg::OP_MULTIPLY: begin
                        // accumulator untouched, no carry or zero flag
                        next_product_high = result[15:8];            // see RULE11
                        next_product_low  = result[7:0];             // see RULE10
                    end
                    lmme_pkg::OP_STORE: begin
                        next_mem_we = 1'b1;                          // see RULE8
                    end
                    lmme_pkg::OP_NONE: begin
                        next_acc = ACC;
                    end
                    default: begin
                        next_acc = ACC;
                    end
                endcase
                next_instr_done = (op != lmme_pkg::OP_NONE);
            end
        endcase
    end

    // ------------------------------------------------------------------
    // registers
    // ------------------------------------------------------------------
    always_ff @(posedge SYS_CLK) begin
        if (!RST_N) begin
            op            <= lmme_pkg::OP_NONE;
            ir            <= lmme_pkg::WORD_RESET;
            lit           <= lmme_pkg::ACC_RESET;
            result        <= lmme_pkg::WORD_RESET;
            ACC           <= lmme_pkg::ACC_RESET;
            BANK_PTR      <= lmme_pkg::BANK_RESET;
            PRODUCT_HIGH  <= lmme_pkg::PROD_RESET;
            PRODUCT_LOW   <= lmme_pkg::PROD_RESET;
            MEM_ADDR      <= lmme_pkg::ADDR_RESET;
            MEM_WDATA     <= lmme_pkg::ACC_RESET;
            MEM_RE        <= 1'b0;
            MEM_WE        <= 1'b0;
            INSTR_DONE    <= 1'b0;
            INSTR_UNKNOWN <= 1'b0;
            read_back     <= lmme_pkg::ACC_RESET;
        end else begin
            op            <= next_op;
            ir            <= next_ir;
            lit           <= next_lit;
            result        <= next_result;
            ACC           <= next_acc;
            BANK_PTR      <= next_bank_ptr;
            PRODUCT_HIGH  <= next_product_high;
            PRODUCT_LOW   <= next_product_low;
            MEM_ADDR      <= next_mem_addr;
            MEM_WDATA     <= next_mem_wdata;
            MEM_RE        <= next_mem_re;
            MEM_WE        <= next_mem_we;
            INSTR_DONE    <= next_instr_done;
            INSTR_UNKNOWN <= next_instr_unknown;
            read_back     <= next_read_back;
        end
    end

endmodule

//--- lmme_pkg.sv
/*
 * constants, opcodes and state encodings for the literal/move/multiply
 * execution block.
 * assumes: one 125 MHz clock; one instruction cycle is four clocks (q1..q4).
 */
package lmme_pkg;

    // ------------------------------------------------------------------
    // widths
    // ------------------------------------------------------------------
    localparam int unsigned INSTR_W = 16;
    localparam int unsigned DATA_W  = 8;
    localparam int unsigned PROD_W  = 16;
    localparam int unsigned ADDR_W  = 12;

    // ------------------------------------------------------------------
    // opcode fields
    // ------------------------------------------------------------------
    localparam logic [7:0] OPC_LOAD_BANK  = 8'h01;
    localparam logic [7:0] OPC_LOAD_ACC   = 8'h0e;
    localparam logic [7:0] OPC_MULTIPLY   = 8'h0d;
    localparam logic [6:0] OPC_STORE      = 7'h37;
    localparam int unsigned OPC_BYTE_LSB  = 8;
    localparam int unsigned OPC_STORE_LSB = 9;
    localparam int unsigned ACCESS_BIT    = 8;

    // ------------------------------------------------------------------
    // addressing
    // ------------------------------------------------------------------
    localparam logic [7:0] BANK_WRITE_MASK = 8'h0f;
    localparam logic [7:0] ACCESS_LOW_MAX  = 8'h5f;
    localparam logic [3:0] ACCESS_LOW_PAGE = 4'h0;
    localparam logic [3:0] ACCESS_HIGH_PAGE = 4'hf;

    // ------------------------------------------------------------------
    // reset values
    // ------------------------------------------------------------------
    localparam logic [7:0]  ACC_RESET  = 8'h00;
    localparam logic [7:0]  BANK_RESET = 8'h00;
    localparam logic [7:0]  PROD_RESET = 8'h00;
    localparam logic [15:0] WORD_RESET = 16'h0000;
    localparam logic [11:0] ADDR_RESET = 12'h000;

    // ------------------------------------------------------------------
    // state types
    // ------------------------------------------------------------------
    typedef enum logic [1:0] {
        PH_Q1 = 2'b00,
        PH_Q2 = 2'b01,
        PH_Q3 = 2'b10,
        PH_Q4 = 2'b11
    } lmme_phase_e;

    typedef enum logic [2:0] {
        OP_NONE      = 3'b000,
        OP_LOAD_BANK = 3'b001,
        OP_LOAD_ACC  = 3'b010,
        OP_STORE     = 3'b011,
        OP_MULTIPLY  = 3'b100
    } lmme_op_e;

endpackage

//--- lmme_phase.sv
/*
 * four-phase sequencer: steps q1, q2, q3, q4 once per clock, repeating.
 * assumes: synchronous active-low reset; restarts at q1 after release.
 */
`timescale 1ns/1ps
module lmme_phase (
    input  wire logic                 clk,    // system clock
    input  wire logic                 rst_n,  // sync reset, active low
    output lmme_pkg::lmme_phase_e     phase   // current phase
);

    lmme_pkg::lmme_phase_e next_phase;

    always_comb begin
        unique case (phase)
            lmme_pkg::PH_Q1: next_phase = lmme_pkg::PH_Q2;
            lmme_pkg::PH_Q2: next_phase = lmme_pkg::PH_Q3;
            lmme_pkg::PH_Q3: next_phase = lmme_pkg::PH_Q4;
            lmme_pkg::PH_Q4: next_phase = lmme_pkg::PH_Q1;
        endcase
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            phase <= lmme_pkg::PH_Q1;
        end else begin
            phase <= next_phase;
        end
    end

endmodule

//--- lmme_mul8.sv
/*
 * unsigned shift-and-add multiplier, purely combinational.
 * assumes: caller registers the product; width is a parameter.
 */
`timescale 1ns/1ps
module lmme_mul8 #(
    parameter int unsigned W = 8
) (
    input  wire logic [W-1:0]   a,  // multiplicand
    input  wire logic [W-1:0]   b,  // multiplier
    output logic      [2*W-1:0] p   // unsigned product
);

    // no carry out: 2*w bits always hold the full product
    always_comb begin
        p = '0;
        for (int i = 0; i < W; i++) begin
            if (b[i]) begin
                p = p + ({{W{1'b0}}, a} << i);
            end
        end
    end

endmodule

//--- lmme_core_sva.sv
/*
 * checker for lmme_core: phase ring, result timing, store strobes, decode.
 * assumes: bound to lmme_core, sees only its ports; one clock domain.
 */
`timescale 1ns/1ps
module lmme_core_chk (
    input wire logic        SYS_CLK,      // clock
    input wire logic        RST_N,        // sync reset
    input wire logic        INSTR_VALID,  // word offered
    input wire logic [15:0] INSTR,        // word
    input wire logic [1:0]  Q_PHASE,      // phase
    input wire logic [7:0]  ACC,          // accumulator
    input wire logic [7:0]  BANK_PTR,     // bank pointer
    input wire logic [7:0]  PRODUCT_HIGH, // product high
    input wire logic [7:0]  PRODUCT_LOW,  // product low
    input wire logic [11:0] MEM_ADDR,     // store address
    input wire logic [7:0]  MEM_WDATA,    // store data
    input wire logic        MEM_RE,       // read strobe
    input wire logic        MEM_WE,       // write strobe
    input wire logic        INSTR_DONE,   // retired
    input wire logic        INSTR_UNKNOWN // not decoded
);
    // ------------------------------------------------------------------
    // decode of the word taken at the end of q1
    // ------------------------------------------------------------------
    default clocking @(posedge SYS_CLK); endclocking
    default disable iff (!RST_N);
    wire       take  = (Q_PHASE == 2'h0) && INSTR_VALID;
    wire [7:0] opc   = INSTR[15:8];
    wire       store = INSTR[15:9] == 7'h37;
    wire       known = store || opc == 8'h01 || opc == 8'h0e || opc == 8'h0d;

    sequence s_ring;
        Q_PHASE == 2'h1 ##1 Q_PHASE == 2'h2 ##1 Q_PHASE == 2'h3 ##1 Q_PHASE == 2'h0;
    endsequence
    sequence s_strobes;
        MEM_RE ##1 !MEM_RE ##1 (MEM_WE && INSTR_DONE) ##1 !MEM_WE;
    endsequence

    // ------------------------------------------------------------------
    // assertions; results land in the q1 cycle after q4, four samples on
    // ------------------------------------------------------------------
    property p_acc;
        logic [7:0] k;
        (take && opc == 8'h0e, k = INSTR[7:0]) |-> ##4 (ACC == k && INSTR_DONE);
    endproperty
    property p_bank;
        logic [7:0] k;
        (take && opc == 8'h01, k = INSTR[7:0]) |-> ##4 BANK_PTR == {4'h0, k[3:0]};
    endproperty
    property p_mul;
        logic [7:0] k, w;
        (take && opc == 8'h0d, k = INSTR[7:0], w = ACC) |->
            ##4 ({PRODUCT_HIGH, PRODUCT_LOW} == {8'h00, k} * {8'h00, w} && ACC == w);
    endproperty
    property p_store(logic sel, logic [11:0] ea);
        logic [11:0] ad;
        logic [7:0]  w;
        (take && store && sel, ad = ea, w = ACC) |->
            ##2 (MEM_ADDR == ad) ##1 (MEM_WDATA == w);
    endproperty

    a_phase_ring: assert property (Q_PHASE == 2'h0 |=> s_ring)
        else $error("phase ring broken");
    a_bank_upper: assert property (BANK_PTR[7:4] == 4'h0)
        else $error("bank pointer upper bits set");
    a_acc_load: assert property (p_acc)
        else $error("accumulator load wrong");
    a_bank_load: assert property (p_bank)
        else $error("bank load wrong");
    a_mul_result: assert property (p_mul)
        else $error("product wrong or accumulator moved");
    a_store_strobes: assert property (take && store |-> ##2 s_strobes)
        else $error("store strobe order wrong");
    a_store_banked: assert property (p_store(INSTR[8], {BANK_PTR[3:0], INSTR[7:0]}))
        else $error("banked store wrong");
    a_store_high: assert property (p_store(!INSTR[8] && INSTR[7:0] > 8'h5f, {4'hf, INSTR[7:0]}))
        else $error("access high store wrong");
    a_unknown_pulse: assert property (take && !known |-> ##1 INSTR_UNKNOWN ##1 !INSTR_UNKNOWN)
        else $error("unknown pulse wrong");
    a_re_phase: assert property (MEM_RE |-> Q_PHASE == 2'h2)
        else $error("read strobe outside q3");
endmodule

bind lmme_core lmme_core_chk u_chk (
    .SYS_CLK, .RST_N, .INSTR_VALID, .INSTR, .Q_PHASE, .ACC, .BANK_PTR, .PRODUCT_HIGH,
    .PRODUCT_LOW, .MEM_ADDR, .MEM_WDATA, .MEM_RE, .MEM_WE, .INSTR_DONE, .INSTR_UNKNOWN
);

//--- literal_move_multiply_exec_tb.sv
/*
 * self-checking bench for lmme_core: directed table then xorshift words.
 * assumes: inputs driven 1 ns after the rising edge; no memory model.
 */
`timescale 1ns/1ps
module literal_move_multiply_exec_tb;
    logic        SYS_CLK, RST_N, INSTR_VALID, EXT_SET_EN, MEM_RE, MEM_WE;
    logic        INSTR_DONE, INSTR_UNKNOWN;
    logic [15:0] INSTR;
    logic [11:0] INDEX_BASE, MEM_ADDR;
    logic [7:0]  MEM_RDATA, ACC, BANK_PTR, PRODUCT_HIGH, PRODUCT_LOW, MEM_WDATA;
    logic [1:0]  Q_PHASE;
    int          fail_count = 0;
    int          cmp_count = 0;
    int          cycles = 0;
    logic [31:0] rs = 32'hdebf;
    logic [7:0]  m_acc = 8'h00;
    logic [7:0]  m_bank = 8'h00;
    logic [15:0] m_prod = 16'h0000;
    logic [15:0] dir [10] = '{16'h01f5, 16'h0ee2, 16'h0dc4, 16'h6e5f, 16'h6e5f,
                              16'h6e60, 16'h6f80, 16'h6cff, 16'h0e00, 16'h0d37};
    logic [7:0]  ops [5] = '{8'h01, 8'h0e, 8'h0d, 8'h6e, 8'h6c};

    lmme_core uut (
        .SYS_CLK, .RST_N, .INSTR_VALID, .INSTR, .EXT_SET_EN, .INDEX_BASE, .MEM_RDATA,
        .Q_PHASE, .ACC, .BANK_PTR, .PRODUCT_HIGH, .PRODUCT_LOW, .MEM_ADDR, .MEM_WDATA,
        .MEM_RE, .MEM_WE, .INSTR_DONE, .INSTR_UNKNOWN
    );

    initial begin
        SYS_CLK = 1'b0;
        forever #4 SYS_CLK = ~SYS_CLK;
    end

    // ------------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------------
    function automatic logic [31:0] xs();
        rs ^= rs << 13;
        rs ^= rs >> 17;
        rs ^= rs << 5;
        return rs;
    endfunction

    task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
        cmp_count++;
        if (g !== e) begin
            fail_count++;
            $display("unexpected %s expected %h seen %h", n, e, g);
        end
    endtask

    task end_of_test;
        $display("compares %0d mismatches %0d", cmp_count, fail_count);
        if (fail_count == 0 && cmp_count > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask

    // one instruction, checked cycle by cycle against the model
    task automatic run(input logic [15:0] w, input logic ext, input logic [11:0] base);
        logic [7:0]  k;
        logic [11:0] ea;
        logic        st, kn;
        int          n;
        k  = w[7:0];
        st = w[15:9] == 7'h37;
        kn = st || w[15:8] inside {8'h01, 8'h0e, 8'h0d};
        if (w[8]) ea = {m_bank[3:0], k};
        else if (k > 8'h5f) ea = {4'hf, k};
        else if (ext) ea = base + {4'h0, k};
        else ea = {4'h0, k};
        n = 0;
        while (Q_PHASE !== 2'h0 && n < 8) begin
            @(posedge SYS_CLK);
            #1;
            n++;
        end
        INSTR = w;
        INSTR_VALID = 1'b1;
        EXT_SET_EN = ext;
        INDEX_BASE = base;
        MEM_RDATA = 8'(xs());
        @(posedge SYS_CLK);
        #1 INSTR_VALID = 1'b0;
        chk("unknown", 16'(!kn), 16'(INSTR_UNKNOWN));
        @(posedge SYS_CLK);
        #1 chk("read strobe", 16'(st), 16'(MEM_RE));
        if (st) chk("address", 16'(ea), 16'(MEM_ADDR));
        @(posedge SYS_CLK);
        #1 if (st) chk("write data", 16'(m_acc), 16'(MEM_WDATA));
        @(posedge SYS_CLK);
        #1 case (w[15:8])
            8'h01: m_bank = {4'h0, k[3:0]};
            8'h0e: m_acc = k;
            8'h0d: m_prod = {8'h00, m_acc} * {8'h00, k};
            default: ;
        endcase
        chk("acc", 16'(m_acc), 16'(ACC));
        chk("bank", 16'(m_bank), 16'(BANK_PTR));
        chk("product", m_prod, {PRODUCT_HIGH, PRODUCT_LOW});
        chk("done", 16'(kn), 16'(INSTR_DONE));
        chk("write strobe", 16'(st), 16'(MEM_WE));
    endtask

    // ------------------------------------------------------------------
    // main sequence and hang guard
    // ------------------------------------------------------------------
    initial begin
        logic [31:0] r;
        RST_N = 1'b0;
        INSTR_VALID = 1'b0;
        INSTR = 16'h0000;
        EXT_SET_EN = 1'b0;
        INDEX_BASE = 12'h000;
        MEM_RDATA = 8'h00;
        repeat (5) @(posedge SYS_CLK);
        #1 RST_N = 1'b1;
        foreach (dir[i]) run(dir[i], i[0], 12'hfc0);
        // a word absent in q1, then offered only in q2..q4, must do nothing
        INSTR = 16'h0e77;
        @(posedge SYS_CLK);
        #1 INSTR_VALID = 1'b1;
        repeat (3) @(posedge SYS_CLK);
        #1 INSTR_VALID = 1'b0;
        chk("idle done", 16'h0000, 16'(INSTR_DONE));
        chk("idle acc", 16'(m_acc), 16'(ACC));
        repeat (150) begin
            r = xs();
            INSTR = {ops[r % 5], r[15:8]};
            if (ops[r % 5] == 8'h6e) INSTR[8] = r[16];
            run(INSTR, r[17], r[29:18]);
        end
        end_of_test;
    end

    // a word takes at most twelve cycles even after a phase wait
    always @(posedge SYS_CLK) begin
        cycles++;
        if (cycles == 3000) begin
            fail_count++;
            end_of_test;
        end
    end
endmodule
